// *** inc/speed_monitor_regs.svh ***
// Constants for the speed limiting and operating stop monitor.
// Operation
// [R01] Compare speed with limit once monitoring runs
// [R02] Speed limit 0..16777215, default 100000
// [R03] Normative speed violation: stop ramp, range low
// [R04] Monitor-only speed violation: only range low; with tolerance enabled the code still requests the stop ramp
// [R05] Activation input is active low
// [R06] Range acknowledge high only armed and within
// [R07] Optional tolerance, off by default, absorbs overshoot
// [R08] Tolerance amplitude 1..25 percent, default 1
// [R09] Overshoot width 1..120000 ms, default 100
// [R10] Overshoot period 2..120000 ms, default 1000
// [R11] Leaving tolerance range requests stop ramp
// [R12] Operating stop armed only by activation input
// [R13] After delay, supervise position within window
// [R14] Latch start position when delay expires
// [R15] Standstill acknowledge only after delay elapsed
// [R16] Operating stop delay 0..120000 ms, default 100
// [R17] Monitor-only stop violation: only standstill low
// [R18] Speed start delay 0..120000 ms, default 20
// [R19] Permanent mode: speed monitored without activation
// [R20] Position window 0..2147483647, default 100
// [R21] Timers use common millisecond tick, restart disarmed
// [R22] Stop ramp request latched until reset
`ifndef SPEED_MONITOR_REGS_SVH
`define SPEED_MONITOR_REGS_SVH
// ----------------------------------------------------------------
// Reset defaults and timing
// ----------------------------------------------------------------
`define SPEED_LIMIT_MAX 24'hFF_FFFF
`define SPEED_LIMIT_DEFAULT 24'h01_86A0
`define TOL_PCT_MIN 5'h01
`define TOL_PCT_MAX 5'h19
`define TOL_PCT_DEFAULT 5'h01
`define TIME_MS_MAX 17'h1_D4C0
`define TOL_WIDTH_DEFAULT 17'h0_0064
`define TOL_PERIOD_MIN 17'h0_0002
`define TOL_PERIOD_DEFAULT 17'h0_03E8
`define STOP_DELAY_DEFAULT 17'h0_0064
`define SPEED_DELAY_DEFAULT 17'h0_0014
`define POS_WINDOW_DEFAULT 31'h0000_0064
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// *** inc/speed_monitor_pkg.sv ***
// Types for the speed limiting and operating stop monitor.
package speed_monitor_pkg;
  typedef enum logic [1:0] {
    SPD_IDLE,
    SPD_DELAY,
    SPD_MONITOR
  } speed_state_t;
  typedef enum logic [1:0] {
    STP_IDLE,
    STP_DELAY,
    STP_MONITOR
  } stop_state_t;
endpackage : speed_monitor_pkg

// *** hdl/safe_speed_standstill_monitor.sv ***
// Speed limiting and operating stop monitor with tolerance range.
`timescale 1ns/1ps
`include "speed_monitor_regs.svh"
module safe_speed_standstill_monitor #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic speed_activation_input_n,
  input wire logic stop_activation_input_n,
  input wire logic speed_permanent,
  input wire logic speed_limiting_monitor_only,
  input wire logic operating_stop_monitor_only,
  input wire logic [23:0] speed_abs,
  input wire logic [31:0] position,
  input wire logic [23:0] speed_limit,
  input wire logic [16:0] speed_delay_ms,
  input wire logic tolerance_enable,
  input wire logic [4:0] tolerance_pct,
  input wire logic [16:0] overshoot_width_ms,
  input wire logic [16:0] overshoot_period_ms,
  input wire logic [16:0] stop_delay_ms,
  input wire logic [30:0] position_window,
  output logic range_acknowledge,
  output logic standstill_acknowledge,
  output logic emergency_stop_ramp_request
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] clamp_ms(input logic [16:0] v, input logic [16:0] lo);
    logic [16:0] r;
    r = v;
    if (r < lo) begin
      r = lo;
    end
    if (r > `TIME_MS_MAX) begin
      r = `TIME_MS_MAX;
    end
    return r;
  endfunction : clamp_ms

  function automatic logic three_sync_agree(input logic [2:0] s);
    return s[1] == s[2];
  endfunction : three_sync_agree

  // The millisecond tick runs free, so a nonzero delay of D ends only after D+1 ticks.
  // Counting D ticks would let it end up to one tick early.
  function automatic logic delay_done(input logic [16:0] ms, input logic [16:0] delay);
    return delay == 17'h0_0000 || ms > delay;
  endfunction : delay_done

  // ----------------------------------------------------------------
  // Activation input synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change is taken once stages two and three agree.
  logic [2:0] spd_sync_q, spd_sync_d, stp_sync_q, stp_sync_d;
  logic spd_act_q, spd_act_d, stp_act_q, stp_act_d;
  always_comb begin
    spd_sync_d = {spd_sync_q[1:0], speed_activation_input_n};
    stp_sync_d = {stp_sync_q[1:0], stop_activation_input_n};
    spd_act_d = spd_act_q;
    stp_act_d = stp_act_q;
    if (three_sync_agree(spd_sync_q)) begin
      spd_act_d = ~spd_sync_q[2]; // [R05]
    end
    if (three_sync_agree(stp_sync_q)) begin
      stp_act_d = ~stp_sync_q[2]; // [R05] [R12]
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      spd_sync_q <= 3'h7;
      stp_sync_q <= 3'h7;
      spd_act_q <= 1'b0;
      stp_act_q <= 1'b0;
    end else begin
      spd_sync_q <= spd_sync_d;
      stp_sync_q <= stp_sync_d;
      spd_act_q <= spd_act_d;
      stp_act_q <= stp_act_d;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [23:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 24'h00_0001;
    if (tick_cnt_q == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 24'h00_0000;
      tick_d = 1'b1; // [R21]
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= 24'h00_0000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Speed limiting
  // ----------------------------------------------------------------
  // The tolerance amplitude is evaluated as speed*100 against limit*(100+pct),
  // which avoids a divider at the cost of two small multipliers.
  speed_monitor_pkg::speed_state_t spd_state_q, spd_state_d;
  logic [16:0] spd_ms_q, spd_ms_d;
  logic [16:0] width_q, width_d;
  logic [16:0] period_q, period_d;
  logic in_excursion_q, in_excursion_d;
  logic period_run_q, period_run_d;
  logic range_fault_q, range_fault_d;
  logic range_ack_q, range_ack_d;
  logic spd_stop_req;
  logic armed, over_limit, over_amp;
  logic [4:0] pct;
  logic [31:0] speed_x100, limit_x_pct;
  always_comb begin
    pct = tolerance_pct;
    if (pct < `TOL_PCT_MIN) begin
      pct = `TOL_PCT_MIN; // [R08]
    end
    if (pct > `TOL_PCT_MAX) begin
      pct = `TOL_PCT_MAX; // [R08]
    end
    speed_x100 = 32'(speed_abs) * 32'h0000_0064;
    limit_x_pct = 32'(speed_limit) * (32'h0000_0064 + 32'(pct));
    over_limit = speed_abs > speed_limit; // [R01] [R02]
    over_amp = speed_x100 > limit_x_pct; // [R08]
    armed = speed_permanent | spd_act_q; // [R19]
    spd_state_d = spd_state_q;
    spd_ms_d = spd_ms_q;
    width_d = width_q;
    period_d = period_q;
    in_excursion_d = in_excursion_q;
    period_run_d = period_run_q;
    range_fault_d = range_fault_q;
    spd_stop_req = 1'b0;
    case (spd_state_q)
      speed_monitor_pkg::SPD_IDLE: begin
        spd_ms_d = 17'h0_0000;
        if (speed_permanent) begin
          spd_state_d = speed_monitor_pkg::SPD_MONITOR; // [R19]
        end else if (spd_act_q) begin
          spd_state_d = speed_monitor_pkg::SPD_DELAY;
        end
      end
      speed_monitor_pkg::SPD_DELAY: begin
        if (delay_done(spd_ms_q, clamp_ms(speed_delay_ms, 17'h0_0000))) begin
          spd_state_d = speed_monitor_pkg::SPD_MONITOR; // [R18]
        end else if (tick_q) begin
          spd_ms_d = spd_ms_q + 17'h0_0001; // [R21]
        end
      end
      speed_monitor_pkg::SPD_MONITOR: begin
        if (tick_q && in_excursion_q) begin
          width_d = width_q + 17'h0_0001;
        end
        if (tick_q && period_run_q) begin
          period_d = period_q + 17'h0_0001;
        end
        if (period_run_q && period_q >= clamp_ms(overshoot_period_ms, `TOL_PERIOD_MIN)) begin
          period_run_d = 1'b0; // [R10]
        end
        if (over_limit) begin // [R01]
          if (!tolerance_enable) begin
            range_fault_d = 1'b1; // [R03] [R04]
            spd_stop_req = ~speed_limiting_monitor_only; // [R03] [R04]
          end else begin
            // [R07]
            if (!in_excursion_q) begin
              in_excursion_d = 1'b1;
              width_d = 17'h0_0000;
              if (period_run_q) begin
                range_fault_d = 1'b1; // [R10] [R11]
                spd_stop_req = 1'b1; // [R11]
              end
              period_run_d = 1'b1;
              period_d = 17'h0_0000;
            end
            if (over_amp || width_q >= clamp_ms(overshoot_width_ms, 17'h0_0001)) begin
              range_fault_d = 1'b1; // [R08] [R09] [R11]
              spd_stop_req = 1'b1; // [R11]
            end
          end
        end else begin
          in_excursion_d = 1'b0;
        end
      end
      default: spd_state_d = speed_monitor_pkg::SPD_IDLE;
    endcase
    if (!armed) begin
      spd_state_d = speed_monitor_pkg::SPD_IDLE; // [R21]
      in_excursion_d = 1'b0;
      period_run_d = 1'b0;
      range_fault_d = 1'b0;
      spd_stop_req = 1'b0;
    end
    range_ack_d = armed && spd_state_d == speed_monitor_pkg::SPD_MONITOR
                  && !range_fault_d; // [R06]
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      spd_state_q <= speed_monitor_pkg::SPD_IDLE;
      spd_ms_q <= 17'h0_0000;
      width_q <= 17'h0_0000;
      period_q <= 17'h0_0000;
      in_excursion_q <= 1'b0;
      period_run_q <= 1'b0;
      range_fault_q <= 1'b0;
      range_ack_q <= 1'b0;
    end else begin
      spd_state_q <= spd_state_d;
      spd_ms_q <= spd_ms_d;
      width_q <= width_d;
      period_q <= period_d;
      in_excursion_q <= in_excursion_d;
      period_run_q <= period_run_d;
      range_fault_q <= range_fault_d;
      range_ack_q <= range_ack_d;
    end
  end

  // ----------------------------------------------------------------
  // Operating stop
  // ----------------------------------------------------------------
  speed_monitor_pkg::stop_state_t stp_state_q, stp_state_d;
  logic [16:0] stp_ms_q, stp_ms_d;
  logic [31:0] start_pos_q, start_pos_d;
  logic stop_fault_q, stop_fault_d;
  logic stand_ack_q, stand_ack_d;
  logic stp_stop_req;
  logic [31:0] pos_diff, pos_mag;
  always_comb begin
    pos_diff = position - start_pos_q;
    pos_mag = pos_diff[31] ? (32'h0000_0000 - pos_diff) : pos_diff;
    stp_state_d = stp_state_q;
    stp_ms_d = stp_ms_q;
    start_pos_d = start_pos_q;
    stop_fault_d = stop_fault_q;
    stp_stop_req = 1'b0;
    case (stp_state_q)
      speed_monitor_pkg::STP_IDLE: begin
        stp_ms_d = 17'h0_0000;
        if (stp_act_q) begin
          stp_state_d = speed_monitor_pkg::STP_DELAY; // [R12]
        end
      end
      speed_monitor_pkg::STP_DELAY: begin
        if (delay_done(stp_ms_q, clamp_ms(stop_delay_ms, 17'h0_0000))) begin
          stp_state_d = speed_monitor_pkg::STP_MONITOR; // [R16]
          start_pos_d = position; // [R14]
        end else if (tick_q) begin
          stp_ms_d = stp_ms_q + 17'h0_0001; // [R21]
        end
      end
      speed_monitor_pkg::STP_MONITOR: begin
        if (pos_mag > {1'b0, position_window}) begin // [R13] [R20]
          stop_fault_d = 1'b1; // [R17] [R20]
          stp_stop_req = ~operating_stop_monitor_only; // [R17] [R20]
        end
      end
      default: stp_state_d = speed_monitor_pkg::STP_IDLE;
    endcase
    if (!stp_act_q) begin
      stp_state_d = speed_monitor_pkg::STP_IDLE; // [R21]
      stop_fault_d = 1'b0;
      stp_stop_req = 1'b0;
    end
    stand_ack_d = stp_state_d == speed_monitor_pkg::STP_MONITOR
                  && !stop_fault_d; // [R15]
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stp_state_q <= speed_monitor_pkg::STP_IDLE;
      stp_ms_q <= 17'h0_0000;
      start_pos_q <= 32'h0000_0000;
      stop_fault_q <= 1'b0;
      stand_ack_q <= 1'b0;
    end else begin
      stp_state_q <= stp_state_d;
      stp_ms_q <= stp_ms_d;
      start_pos_q <= start_pos_d;
      stop_fault_q <= stop_fault_d;
      stand_ack_q <= stand_ack_d;
    end
  end

  // ----------------------------------------------------------------
  // Emergency stop request
  // ----------------------------------------------------------------
  // Latched so that a drive that recovers on its own still brakes.
  logic estop_q, estop_d;
  always_comb begin
    estop_d = estop_q | spd_stop_req | stp_stop_req; // [R22] [R03] [R11]
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      estop_q <= 1'b0;
    end else begin
      estop_q <= estop_d;
    end
  end

  assign range_acknowledge = range_ack_q;
  assign standstill_acknowledge = stand_ack_q;
  assign emergency_stop_ramp_request = estop_q;
endmodule : safe_speed_standstill_monitor

// *** test/motor_feedback_model.sv ***
// Model of the encoder feedback and the activation wiring.
`timescale 1ns/1ps
module motor_feedback_model (
  input wire logic core_clk,
  input wire logic [23:0] speed_cmd,
  input wire logic [31:0] pos_cmd,
  input wire logic speed_arm,
  input wire logic stop_arm,
  output logic [23:0] speed_abs,
  output logic [31:0] position,
  output logic speed_activation_input_n,
  output logic stop_activation_input_n
);
  // Values move on the falling edge, clear of the sampling edge.
  initial begin
    speed_abs = 24'h00_0000;
    position = 32'h0000_0000;
    speed_activation_input_n = 1'b1;
    stop_activation_input_n = 1'b1;
  end
  always @(negedge core_clk) begin
    speed_abs <= speed_cmd;
    position <= pos_cmd;
    speed_activation_input_n <= !speed_arm;
    stop_activation_input_n <= !stop_arm;
  end
endmodule : motor_feedback_model

// *** test/speed_monitor_chk.sv ***
// Port checker of the speed and standstill monitor.
`timescale 1ns/1ps
module speed_monitor_chk #(
  parameter int TICK_CYCLES = 10000
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic speed_activation_input_n,
  input wire logic stop_activation_input_n,
  input wire logic speed_permanent,
  input wire logic speed_limiting_monitor_only,
  input wire logic operating_stop_monitor_only,
  input wire logic [23:0] speed_abs,
  input wire logic [23:0] speed_limit,
  input wire logic [16:0] speed_delay_ms,
  input wire logic tolerance_enable,
  input wire logic [16:0] stop_delay_ms,
  input wire logic range_acknowledge,
  input wire logic standstill_acknowledge,
  input wire logic emergency_stop_ramp_request
);
  // ------
  // Cycles each activation pin has been low
  // ------
  logic [31:0] spd_cnt_q, spd_cnt_d, stp_cnt_q, stp_cnt_d;
  always_comb begin
    spd_cnt_d = speed_activation_input_n ? 32'h0000_0000 : spd_cnt_q + 32'h0000_0001;
    stp_cnt_d = stop_activation_input_n ? 32'h0000_0000 : stp_cnt_q + 32'h0000_0001;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      spd_cnt_q <= 32'h0000_0000;
      stp_cnt_q <= 32'h0000_0000;
    end else begin
      spd_cnt_q <= spd_cnt_d;
      stp_cnt_q <= stp_cnt_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  stop_latch_a: assert property (emergency_stop_ramp_request |=> emergency_stop_ramp_request)
    else $error("stop request dropped");
  range_off_a: assert property ((speed_activation_input_n && !speed_permanent) [*6]
    |-> !range_acknowledge) else $error("range ack while disarmed");
  stand_off_a: assert property (stop_activation_input_n [*6] |-> !standstill_acknowledge)
    else $error("standstill ack while disarmed");
  speed_fault_a: assert property (range_acknowledge && !tolerance_enable && speed_abs > speed_limit
    |=> !range_acknowledge) else $error("range ack kept over limit");
  fault_stop_a: assert property (range_acknowledge && !tolerance_enable
    && speed_abs > speed_limit && !speed_limiting_monitor_only |=> emergency_stop_ramp_request)
    else $error("no stop request over limit");
  quiet_mon_a: assert property ($rose(emergency_stop_ramp_request) |->
    !$past(speed_limiting_monitor_only) || !$past(operating_stop_monitor_only)
    || $past(tolerance_enable)) else $error("stop request in monitor-only");
  range_wait_a: assert property ($rose(range_acknowledge) |->
    speed_permanent || spd_cnt_q >= speed_delay_ms * TICK_CYCLES)
    else $error("range ack before delay");
  stand_wait_a: assert property ($rose(standstill_acknowledge) |->
    stp_cnt_q >= stop_delay_ms * TICK_CYCLES) else $error("standstill ack before delay");
  reset_clear_a: assert property ($fell(reset) |-> !range_acknowledge
    && !standstill_acknowledge && !emergency_stop_ramp_request) else $error("outputs after reset");
endmodule : speed_monitor_chk
bind safe_speed_standstill_monitor speed_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) i_speed_monitor_chk (
  .core_clk, .reset, .speed_activation_input_n, .stop_activation_input_n, .speed_permanent,
  .speed_limiting_monitor_only, .operating_stop_monitor_only, .speed_abs, .speed_limit,
  .speed_delay_ms, .tolerance_enable, .stop_delay_ms, .range_acknowledge,
  .standstill_acknowledge, .emergency_stop_ramp_request);

// *** test/safe_speed_standstill_monitor_bench.sv ***
// Self-checking bench of the speed and standstill monitor.
`timescale 1ns/1ps
module safe_speed_standstill_monitor_bench;
  // ------
  // Stimulus and wiring
  // ------
  localparam int TICK = 10;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic speed_permanent = 1'b0, speed_limiting_monitor_only = 1'b0;
  logic operating_stop_monitor_only = 1'b0, tolerance_enable = 1'b0;
  logic [23:0] speed_limit = 24'h00_03E8, speed_cmd = 24'h00_0000, speed_abs;
  logic [16:0] speed_delay_ms = 17'h0_0003, stop_delay_ms = 17'h0_0002;
  logic [16:0] overshoot_width_ms = 17'h0_0005, overshoot_period_ms = 17'h0_0014;
  logic [4:0] tolerance_pct = 5'h0A;
  logic [30:0] position_window = 31'h0000_0064;
  logic [31:0] pos_cmd = 32'h0000_0000, position;
  logic speed_arm = 1'b0, stop_arm = 1'b0, speed_activation_input_n, stop_activation_input_n;
  logic range_acknowledge, standstill_acknowledge, emergency_stop_ramp_request;
  int error_cnt = 0, checks_done = 0;
  always #50 core_clk = ~core_clk;
  motor_feedback_model i_motor_feedback_model (.core_clk, .speed_cmd, .pos_cmd, .speed_arm,
    .stop_arm, .speed_abs, .position, .speed_activation_input_n, .stop_activation_input_n);
  safe_speed_standstill_monitor #(.TICK_CYCLES(TICK)) i_safe_speed_standstill_monitor (
    .core_clk, .reset, .speed_activation_input_n, .stop_activation_input_n, .speed_permanent,
    .speed_limiting_monitor_only, .operating_stop_monitor_only, .speed_abs, .position,
    .speed_limit, .speed_delay_ms, .tolerance_enable, .tolerance_pct, .overshoot_width_ms,
    .overshoot_period_ms, .stop_delay_ms, .position_window, .range_acknowledge,
    .standstill_acknowledge, .emergency_stop_ramp_request);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // The stop request latches, so every scenario starts from reset.
  task automatic do_reset;
    @(negedge core_clk);
    reset <= 1'b1;
    {speed_arm, stop_arm, speed_permanent, tolerance_enable} <= 4'h0;
    {speed_limiting_monitor_only, operating_stop_monitor_only} <= 2'b00;
    speed_limit <= 24'h00_03E8;
    speed_cmd <= 24'h00_0000;
    pos_cmd <= 32'h0000_0000;
    cyc(2);
    reset <= 1'b0;
    cyc(1);
  endtask : do_reset
  task automatic wait_ack(input bit stand, output int n);
    n = 0;
    while ((stand ? standstill_acknowledge : range_acknowledge) !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 3000) begin
        error_cnt++;
        tally_and_finish();
      end
    end
  endtask : wait_ack
  task automatic t_speed_norm;
    int n;
    do_reset();
    speed_cmd <= 24'h00_03E8;
    speed_arm <= 1'b1;
    wait_ack(1'b0, n);
    check("range delay", n >= 3 * TICK && n <= 4 * TICK + 12, 1'b1);
    cyc(5);
    check("range at limit", range_acknowledge, 1'b1);
    speed_cmd <= 24'h00_03E9;
    cyc(3);
    check("range over", range_acknowledge, 1'b0);
    check("stop over", emergency_stop_ramp_request, 1'b1);
    speed_cmd <= 24'h00_0000;
    speed_arm <= 1'b0;
    cyc(8);
    check("stop held", emergency_stop_ramp_request, 1'b1);
    check("range off", range_acknowledge, 1'b0);
  endtask : t_speed_norm
  task automatic t_speed_mon;
    int n;
    do_reset();
    speed_limiting_monitor_only <= 1'b1;
    operating_stop_monitor_only <= 1'b1;
    speed_limit <= 24'hFF_FFFF;
    speed_delay_ms <= 17'h0_0000;
    speed_cmd <= 24'hFF_FFFF;
    speed_arm <= 1'b1;
    wait_ack(1'b0, n);
    check("zero delay", n <= 12, 1'b1);
    cyc(5);
    check("range at max", range_acknowledge, 1'b1);
    speed_limit <= 24'h00_03E8;
    cyc(3);
    check("mon range", range_acknowledge, 1'b0);
    check("mon stop", emergency_stop_ramp_request, 1'b0);
    speed_delay_ms <= 17'h0_0003;
  endtask : t_speed_mon
  task automatic t_permanent;
    int n;
    do_reset();
    speed_permanent <= 1'b1;
    speed_cmd <= 24'h00_01F4;
    wait_ack(1'b0, n);
    check("permanent start", n <= 8, 1'b1);
    check("no permanent stop", standstill_acknowledge, 1'b0);
  endtask : t_permanent
  task automatic t_tol;
    int sp[4] = '{1050, 1101, 1050, 1050};
    int ms[4] = '{2, 1, 7, 2};
    int reps[4] = '{1, 1, 1, 2};
    int n;
    for (int i = 0; i < 4; i++) begin
      do_reset();
      tolerance_enable <= 1'b1;
      speed_arm <= 1'b1;
      wait_ack(1'b0, n);
      for (int r = 0; r < reps[i]; r++) begin
        speed_cmd <= 24'(sp[i]);
        cyc(ms[i] * TICK);
        speed_cmd <= 24'h00_0384;
        cyc(5 * TICK);
      end
      check("tolerance stop", emergency_stop_ramp_request, i != 0);
    end
  endtask : t_tol
  task automatic t_stand(input bit mo);
    int n;
    do_reset();
    operating_stop_monitor_only <= mo;
    speed_limiting_monitor_only <= mo;
    stop_arm <= 1'b1;
    cyc(1);
    pos_cmd <= 32'h0000_1388;
    wait_ack(1'b1, n);
    check("stand delay", n >= 2 * TICK - 1 && n <= 3 * TICK + 12, 1'b1);
    pos_cmd <= 32'h0000_13EC;
    cyc(4);
    check("stand edge", standstill_acknowledge, 1'b1);
    pos_cmd <= mo ? 32'h0000_1323 : 32'h0000_13ED;
    cyc(4);
    check("stand out", standstill_acknowledge, 1'b0);
    check("stand stop", emergency_stop_ramp_request, !mo);
  endtask : t_stand
  initial begin
    do_reset();
    check("reset outs", {range_acknowledge, standstill_acknowledge,
      emergency_stop_ramp_request}, 3'b000);
    t_speed_norm();
    t_speed_mon();
    t_permanent();
    t_tol();
    t_stand(1'b0);
    t_stand(1'b1);
    tally_and_finish();
  end
endmodule : safe_speed_standstill_monitor_bench
